// file: src/chip_cfg_map.vh
// Register map, field layout, reset values and codes of the chip configuration bank.
`ifndef CHIP_CFG_MAP_VH
`define CHIP_CFG_MAP_VH

// ==========================================================================
// Bus and register map
`define ADDR_W          12
`define OFS_CFG0        12'h000
`define OFS_CFG1        12'h004
`define OFS_CFG2        12'h008
`define SEL_CFG0        2'h0
`define SEL_CFG1        2'h1
`define SEL_CFG2        2'h2
`define SEL_NONE        2'h3
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// ==========================================================================
// Reset values and writable masks
`define CFG0_RST        32'h00000000
`define CFG0_WMASK      32'h0000001F
`define CFG1_RST        32'h00000000
`define CFG1_WMASK      32'hFFFFFFFF
`define CFG2_RST        32'h0000EF00
`define CFG2_WMASK      32'h0000FFC0

// ==========================================================================
// Field positions
`define CFG0_LOCK_BIT   4
`define CFG0_TC1_RANGE  3:2
`define CFG0_TC0_RANGE  1:0
`define CAP_SRC_BASE    17
`define CAP_SRC_W       5
`define CFG1_BYTEAD_BIT 16
`define CFG1_HPEN_BIT   15
`define CFG1_DMA1_RANGE 14:13
`define CFG1_SYNC_BIT   12
`define CFG1_MUTE_RANGE 3:0
`define CFG2_CLKGD_BIT  17
`define CFG2_VBUS_BIT   16
`define CFG2_RESET_BIT  15
`define CFG2_OTG_RANGE  14:13
`define CFG2_CLKMUX_BIT 11
`define CFG2_PWDN_BIT   10
`define CFG2_OTGPD_BIT  9
`define CFG2_POL_BIT    8
`define CFG2_PLLON_BIT  6

// ==========================================================================
// Field codes
`define BURST_CODE_16   2'h0
`define BURST_CODE_32   2'h1
`define BURST_CODE_64   2'h2
`define BURST_BYTES_16  7'h10
`define BURST_BYTES_32  7'h20
`define BURST_BYTES_64  7'h40
`define CAP_SRC_PIN     5'h00
`define CAP_SRC_TX      5'h01
`define CAP_SRC_RX      5'h02
`define MUTE_SRC_LOW    4'h0
`define MUTE_SRC_LAST   4'h8
`define MUTE_SRC_FIRST  4'h1
`define OTG_NO_OVR      2'h0
`define OTG_FORCE_HOST  2'h1
`define OTG_FORCE_DEV   2'h2
`define OTG_HOST_VBLOW  2'h3

`endif

// file: src/chip_config_regs.v
// Chip configuration register bank with an AXI4-Lite slave port.
`include "chip_cfg_map.vh"
`default_nettype none

// Behaviour
// - Lock bit blocks primary PLL controller writes
// - DMA0 TC1 burst: 16, 32, 64 bytes
// - DMA0 TC0 burst: 16, 32, 64 bytes
// - All burst fields reset to 16 bytes
// - Capture source: pin, audio TX, audio RX
// - Host port address: word 0, byte 1
// - Host port enable owns its pins
// - DMA1 TC0 burst: 16, 32, 64 bytes
// - Sync bit low stops PWM time-base clocks
// - Sync bit high starts time-bases together
// - Mute source: low or GPIO bank 0-7
// - Clock-good reads clock, power, PLL all good
// - Bus-voltage sense reads PHY VBUS presence
// - PHY reset bit holds PHY, resets 1
// - OTG override: pass, host, device, host-low
// - Refclk select: external pin or aux clock
// - PHY power-down bit disables PHY
// - OTG subsystem power-down bit
// - Polarity bit zero swaps data pads
// - PLL-on zero lets PHY stop clock
module chip_config_regs (
	// Clock and reset
	input  wire        i_mclk,
	input  wire        i_arst_n,
	// AXI4-Lite write channels
	input  wire [11:0] i_awaddr,
	input  wire        i_awvalid,
	output wire        o_awready,
	input  wire [31:0] i_wdata,
	input  wire [3:0]  i_wstrb,
	input  wire        i_wvalid,
	output wire        o_wready,
	output wire [1:0]  o_bresp,
	output wire        o_bvalid,
	input  wire        i_bready,
	// AXI4-Lite read channels
	input  wire [11:0] i_araddr,
	input  wire        i_arvalid,
	output wire        o_arready,
	output wire [31:0] o_rdata,
	output wire [1:0]  o_rresp,
	output wire        o_rvalid,
	input  wire        i_rready,
	// Event and status inputs
	input  wire [2:0]  i_capture_pin,
	input  wire        i_audio_tx_dma_event,
	input  wire        i_audio_rx_dma_event,
	input  wire [7:0]  i_gpio_bank_irq,
	input  wire        i_phy_clk_present,
	input  wire        i_phy_power_good,
	input  wire        i_phy_pll_locked,
	input  wire        i_phy_vbus_sense,
	input  wire        i_phy_vbus_valid,
	input  wire        i_phy_id_dig,
	// Configuration outputs
	output wire        o_pll_ctrl_write_lock,
	output wire [6:0]  o_dma0_tc0_burst_bytes,
	output wire [6:0]  o_dma0_tc1_burst_bytes,
	output wire [6:0]  o_dma1_tc0_burst_bytes,
	output wire [2:0]  o_capture_event,
	output wire        o_host_port_byte_addr_mode,
	output wire        o_host_port_enable,
	output wire        o_pwm_timebase_clk_run,
	output wire        o_audio_mute_input,
	// USB PHY control outputs
	output wire        o_phy_reset,
	output wire        o_ctrl_vbus_valid,
	output wire        o_ctrl_id_dig,
	output wire        o_phy_refclk_select,
	output wire        o_phy_power_down,
	output wire        o_otg_subsystem_power_down,
	output wire        o_data_line_polarity,
	output wire        o_phy_pll_keep_on
);

	// ======================================================================
	// Helper functions

	function [1:0] reg_sel;
		input [11:0] addr;
		begin
			case (addr)
				`OFS_CFG0: reg_sel = `SEL_CFG0;
				`OFS_CFG1: reg_sel = `SEL_CFG1;
				`OFS_CFG2: reg_sel = `SEL_CFG2;
				default:   reg_sel = `SEL_NONE;
			endcase
		end
	endfunction

	function [31:0] merge_strb;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0]  strb;
		integer k;
		begin
			for (k = 0; k < 4; k = k + 1) begin
				merge_strb[k*8 +: 8] = strb[k] ? new_val[k*8 +: 8] : old_val[k*8 +: 8];
			end
		end
	endfunction

	// The reserved code falls back to the smallest burst, the safe choice.
	function [6:0] burst_bytes;
		input [1:0] code;
		begin
			case (code)
				`BURST_CODE_16: burst_bytes = `BURST_BYTES_16;
				`BURST_CODE_32: burst_bytes = `BURST_BYTES_32;
				`BURST_CODE_64: burst_bytes = `BURST_BYTES_64;
				default:        burst_bytes = `BURST_BYTES_16;
			endcase
		end
	endfunction

	// Reserved source codes feed nothing, so a stray code cannot fake an event.
	function cap_pick;
		input [4:0] code;
		input       pin;
		input       tx;
		input       rx;
		begin
			case (code)
				`CAP_SRC_PIN: cap_pick = pin;
				`CAP_SRC_TX:  cap_pick = tx;
				`CAP_SRC_RX:  cap_pick = rx;
				default:      cap_pick = 1'b0;
			endcase
		end
	endfunction

	// ======================================================================
	// Storage

	reg [31:0] cfg0_reg;
	reg [31:0] cfg1_reg;
	reg [31:0] cfg2_reg;
	reg        clk_good_reg;
	reg        vbus_sense_reg;

	reg        awready_reg;
	reg        wready_reg;
	reg        aw_got_reg;
	reg        w_got_reg;
	reg [11:0] awaddr_reg;
	reg [31:0] wdata_reg;
	reg [3:0]  wstrb_reg;
	reg        bvalid_reg;
	reg [1:0]  bresp_reg;
	reg        arready_reg;
	reg        rvalid_reg;
	reg [31:0] rdata_reg;
	reg [1:0]  rresp_reg;

	reg [6:0]  dma0_tc0_reg;
	reg [6:0]  dma0_tc1_reg;
	reg [6:0]  dma1_tc0_reg;
	reg [2:0]  capture_reg;
	reg        mute_reg;
	reg        ctrl_vbus_reg;
	reg        ctrl_id_reg;

	wire       do_write;
	wire [1:0] wsel;
	wire [1:0] rsel;
	reg [31:0] read_next;
	reg        mute_next;
	reg        ctrl_vbus_next;
	reg        ctrl_id_next;
	wire [3:0] mute_code;
	wire [3:0] mute_idx;
	wire [2:0] capture_next;

	assign do_write = aw_got_reg & w_got_reg;
	assign wsel     = reg_sel(awaddr_reg);
	assign rsel     = reg_sel(i_araddr);

	// ======================================================================
	// AXI4-Lite write path
	// Address and data are latched separately so either may arrive first.

	always @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			aw_got_reg  <= 1'b0;
			w_got_reg   <= 1'b0;
			awaddr_reg  <= 12'h000;
			wdata_reg   <= 32'h00000000;
			wstrb_reg   <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `RESP_OKAY;
		end else begin
			if (awready_reg && i_awvalid) begin
				awaddr_reg  <= i_awaddr;
				aw_got_reg  <= 1'b1;
				awready_reg <= 1'b0;
			end
			if (wready_reg && i_wvalid) begin
				wdata_reg  <= i_wdata;
				wstrb_reg  <= i_wstrb;
				w_got_reg  <= 1'b1;
				wready_reg <= 1'b0;
			end
			if (do_write) begin
				aw_got_reg <= 1'b0;
				w_got_reg  <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg  <= (wsel == `SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
			end
			if (bvalid_reg && i_bready) begin
				bvalid_reg  <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg  <= 1'b1;
			end
		end
	end

	// ======================================================================
	// Register file

	always @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cfg0_reg <= `CFG0_RST;
			cfg1_reg <= `CFG1_RST;
			cfg2_reg <= `CFG2_RST;
		end else if (do_write) begin
			// Masks keep read-only and read-zero bits out of storage.
			case (wsel)
				`SEL_CFG0: cfg0_reg <= merge_strb(cfg0_reg, wdata_reg, wstrb_reg) & `CFG0_WMASK;
				`SEL_CFG1: cfg1_reg <= merge_strb(cfg1_reg, wdata_reg, wstrb_reg) & `CFG1_WMASK;
				`SEL_CFG2: cfg2_reg <= merge_strb(cfg2_reg, wdata_reg, wstrb_reg) & `CFG2_WMASK;
				default: begin
				end
			endcase
		end
	end

	// PHY status is registered on every clock so a read sees a stable value.
	always @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			clk_good_reg   <= 1'b0;
			vbus_sense_reg <= 1'b0;
		end else begin
			clk_good_reg   <= i_phy_clk_present & i_phy_power_good & i_phy_pll_locked;
			vbus_sense_reg <= i_phy_vbus_sense;
		end
	end

	// ======================================================================
	// AXI4-Lite read path

	always @* begin
		read_next = 32'h00000000;
		case (rsel)
			`SEL_CFG0: read_next = cfg0_reg;
			`SEL_CFG1: read_next = cfg1_reg;
			`SEL_CFG2: begin
				read_next = cfg2_reg & `CFG2_WMASK;
				read_next[`CFG2_CLKGD_BIT] = clk_good_reg;
				read_next[`CFG2_VBUS_BIT]  = vbus_sense_reg;
			end
			default: read_next = 32'h00000000;
		endcase
	end

	always @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h00000000;
			rresp_reg   <= `RESP_OKAY;
		end else if (arready_reg && i_arvalid) begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b1;
			rdata_reg   <= read_next;
			rresp_reg   <= (rsel == `SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
		end else if (rvalid_reg && i_rready) begin
			rvalid_reg  <= 1'b0;
			arready_reg <= 1'b1;
		end
	end

	// ======================================================================
	// Decoded steering outputs

	assign mute_code = cfg1_reg[`CFG1_MUTE_RANGE];
	assign mute_idx  = mute_code - `MUTE_SRC_FIRST;

	always @* begin
		mute_next = 1'b0;
		if (mute_code != `MUTE_SRC_LOW && mute_code <= `MUTE_SRC_LAST) begin
			mute_next = i_gpio_bank_irq[mute_idx[2:0]];
		end
	end

	always @* begin
		case (cfg2_reg[`CFG2_OTG_RANGE])
			`OTG_NO_OVR: begin
				ctrl_vbus_next = i_phy_vbus_valid;
				ctrl_id_next   = i_phy_id_dig;
			end
			`OTG_FORCE_HOST: begin
				ctrl_vbus_next = 1'b1;
				ctrl_id_next   = 1'b0;
			end
			`OTG_FORCE_DEV: begin
				ctrl_vbus_next = 1'b1;
				ctrl_id_next   = 1'b1;
			end
			default: begin
				ctrl_vbus_next = 1'b0;
				ctrl_id_next   = 1'b0;
			end
		endcase
	end

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_capture
			wire [4:0] src;
			assign src = cfg1_reg[`CAP_SRC_BASE + `CAP_SRC_W*g +: `CAP_SRC_W];
			assign capture_next[g] = cap_pick(src, i_capture_pin[g], i_audio_tx_dma_event,
				i_audio_rx_dma_event);
		end
	endgenerate

	always @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			dma0_tc0_reg  <= `BURST_BYTES_16;
			dma0_tc1_reg  <= `BURST_BYTES_16;
			dma1_tc0_reg  <= `BURST_BYTES_16;
			mute_reg      <= 1'b0;
			ctrl_vbus_reg <= 1'b0;
			ctrl_id_reg   <= 1'b0;
			capture_reg   <= 3'h0;
		end else begin
			dma0_tc0_reg  <= burst_bytes(cfg0_reg[`CFG0_TC0_RANGE]);
			dma0_tc1_reg  <= burst_bytes(cfg0_reg[`CFG0_TC1_RANGE]);
			dma1_tc0_reg  <= burst_bytes(cfg1_reg[`CFG1_DMA1_RANGE]);
			mute_reg      <= mute_next;
			ctrl_vbus_reg <= ctrl_vbus_next;
			ctrl_id_reg   <= ctrl_id_next;
			capture_reg   <= capture_next;
		end
	end

	// ======================================================================
	// Output assignments

	assign o_awready = awready_reg;
	assign o_wready  = wready_reg;
	assign o_bvalid  = bvalid_reg;
	assign o_bresp   = bresp_reg;
	assign o_arready = arready_reg;
	assign o_rvalid  = rvalid_reg;
	assign o_rdata   = rdata_reg;
	assign o_rresp   = rresp_reg;

	// The PLL controller refuses its own register writes while this is high.
	assign o_pll_ctrl_write_lock      = cfg0_reg[`CFG0_LOCK_BIT];
	assign o_dma0_tc0_burst_bytes     = dma0_tc0_reg;
	assign o_dma0_tc1_burst_bytes     = dma0_tc1_reg;
	assign o_dma1_tc0_burst_bytes     = dma1_tc0_reg;
	assign o_capture_event            = capture_reg;
	assign o_host_port_byte_addr_mode = cfg1_reg[`CFG1_BYTEAD_BIT];
	assign o_host_port_enable         = cfg1_reg[`CFG1_HPEN_BIT];
	// One shared run level starts every time-base on the same edge.
	assign o_pwm_timebase_clk_run     = cfg1_reg[`CFG1_SYNC_BIT];
	assign o_audio_mute_input         = mute_reg;
	assign o_phy_reset                = cfg2_reg[`CFG2_RESET_BIT];
	assign o_ctrl_vbus_valid          = ctrl_vbus_reg;
	assign o_ctrl_id_dig              = ctrl_id_reg;
	assign o_phy_refclk_select        = cfg2_reg[`CFG2_CLKMUX_BIT];
	assign o_phy_power_down           = cfg2_reg[`CFG2_PWDN_BIT];
	assign o_otg_subsystem_power_down = cfg2_reg[`CFG2_OTGPD_BIT];
	assign o_data_line_polarity       = cfg2_reg[`CFG2_POL_BIT];
	assign o_phy_pll_keep_on          = cfg2_reg[`CFG2_PLLON_BIT];

endmodule // chip_config_regs

`default_nettype wire

// file: bench/chip_config_regs_assertions.sv
// Port checker for the chip configuration bank.
`default_nettype none
// ========
// Checker
module chip_config_regs_assertions (
	// Clock, reset and bus
	input wire logic        i_mclk,
	input wire logic        i_arst_n,
	input wire logic        i_awvalid,
	input wire logic        o_awready,
	input wire logic        i_wvalid,
	input wire logic        o_wready,
	input wire logic [1:0]  o_bresp,
	input wire logic        o_bvalid,
	input wire logic        i_bready,
	input wire logic        i_arvalid,
	input wire logic        o_arready,
	input wire logic [31:0] o_rdata,
	input wire logic        o_rvalid,
	input wire logic        i_rready,
	// Sources and decoded outputs
	input wire logic [2:0]  i_capture_pin,
	input wire logic        i_audio_tx_dma_event,
	input wire logic        i_audio_rx_dma_event,
	input wire logic [7:0]  i_gpio_bank_irq,
	input wire logic [6:0]  o_dma0_tc0_burst_bytes,
	input wire logic [6:0]  o_dma0_tc1_burst_bytes,
	input wire logic [6:0]  o_dma1_tc0_burst_bytes,
	input wire logic [2:0]  o_capture_event,
	input wire logic        o_audio_mute_input
);
	timeunit 1ns;
	timeprecision 1ns;
	wire any_irq;
	// Decoded outputs follow their sources by exactly one edge.
	assign any_irq = |i_gpio_bank_irq;
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_arst_n);
	a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready
		|-> ##[1:2] o_bvalid) else $error("write response late");
	a_bresp_held: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
		else $error("write response dropped");
	a_ready_pending: assert property (o_bvalid |-> !o_awready && !o_wready)
		else $error("ready during pending write");
	a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
		else $error("read answer late");
	a_rdata_held: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
		else $error("read data dropped");
	a_burst_legal: assert property (
		o_dma0_tc0_burst_bytes inside {7'h10, 7'h20, 7'h40} &&
		o_dma0_tc1_burst_bytes inside {7'h10, 7'h20, 7'h40} &&
		o_dma1_tc0_burst_bytes inside {7'h10, 7'h20, 7'h40}) else $error("burst size illegal");
	a_mute_cause: assert property (o_audio_mute_input |-> $past(any_irq))
		else $error("mute without source");
	a_capture_cause: assert property ((o_capture_event & ~$past(i_capture_pin)) != 3'h0
		|-> $past(i_audio_tx_dma_event || i_audio_rx_dma_event))
		else $error("capture without source");
	c_write: cover property (o_bvalid && i_bready);
	c_read: cover property (o_rvalid && i_rready);
	c_mute: cover property (o_audio_mute_input);
endmodule // chip_config_regs_assertions

bind chip_config_regs chip_config_regs_assertions i_chk (
	.i_mclk, .i_arst_n, .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bresp, .o_bvalid,
	.i_bready, .i_arvalid, .o_arready, .o_rdata, .o_rvalid, .i_rready, .i_capture_pin,
	.i_audio_tx_dma_event, .i_audio_rx_dma_event, .i_gpio_bank_irq, .o_dma0_tc0_burst_bytes,
	.o_dma0_tc1_burst_bytes, .o_dma1_tc0_burst_bytes, .o_capture_event, .o_audio_mute_input
);
`default_nettype wire

// file: bench/chip_periph_model.sv
// Behavioural model of the USB PHY status seen by the configuration bank.
`default_nettype none
// ========
// PHY model
module chip_periph_model (
	// Clock, reset and bench knob
	input  wire logic i_mclk,
	input  wire logic i_arst_n,
	input  wire logic i_vbus_on,
	// Controls from the bank
	input  wire logic i_phy_reset,
	input  wire logic i_phy_power_down,
	// Status to the bank
	output var  logic o_phy_clk_present,
	output var  logic o_phy_power_good,
	output var  logic o_phy_pll_locked,
	output var  logic o_phy_vbus_sense
);
	timeunit 1ns;
	timeprecision 1ns;
	// The PLL needs a cycle of running clock before it reports lock.
	always @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_phy_pll_locked <= 1'b0;
		end else begin
			o_phy_pll_locked <= o_phy_clk_present;
		end
	end
	always @* begin
		o_phy_power_good = !i_phy_power_down;
		o_phy_clk_present = !i_phy_power_down && !i_phy_reset;
		o_phy_vbus_sense = i_vbus_on;
	end
endmodule // chip_periph_model
`default_nettype wire

// file: bench/chip_config_regs_tb_top.sv
// Self-checking testbench for the chip configuration bank.
`default_nettype none
// ========
// Testbench
module chip_config_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic [11:0] a; logic [31:0] d, e; logic [1:0] r;} row_t;
	logic        i_mclk, i_arst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
	logic [11:0] i_awaddr, i_araddr;
	logic [31:0] i_wdata, o_rdata, rdat, d;
	logic [3:0]  i_wstrb;
	logic [1:0]  o_bresp, o_rresp, rsp;
	logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, vbus_on;
	logic [2:0]  i_capture_pin, o_capture_event;
	logic        i_audio_tx_dma_event, i_audio_rx_dma_event, i_phy_vbus_valid, i_phy_id_dig;
	logic [7:0]  i_gpio_bank_irq;
	logic        i_phy_clk_present, i_phy_power_good, i_phy_pll_locked, i_phy_vbus_sense;
	logic [6:0]  o_dma0_tc0_burst_bytes, o_dma0_tc1_burst_bytes, o_dma1_tc0_burst_bytes, bx;
	logic        o_pll_ctrl_write_lock, o_host_port_byte_addr_mode, o_host_port_enable;
	logic        o_pwm_timebase_clk_run, o_audio_mute_input, o_phy_reset, o_ctrl_vbus_valid;
	logic        o_ctrl_id_dig, o_phy_refclk_select, o_phy_power_down, o_phy_pll_keep_on;
	logic        o_otg_subsystem_power_down, o_data_line_polarity;
	int          miscompares = 0, n_tests = 0, k, v, p;
	row_t        rows [6] = '{
		'{12'h000, 32'hFFFFFFFF, 32'h0000001F, 2'h0}, '{12'h000, 32'h00000006, 32'h00000006, 2'h0},
		'{12'h004, 32'hA5A5A5A5, 32'hA5A5A5A5, 2'h0}, '{12'h008, 32'hFFFFFFFF, 32'h0000FFC0, 2'h0},
		'{12'h00C, 32'h12345678, 32'h00000000, 2'h2}, '{12'hFFC, 32'h0000FFFF, 32'h00000000, 2'h2}};
	chip_config_regs i_dut (.i_mclk, .i_arst_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
		.i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
		.o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_capture_pin,
		.i_audio_tx_dma_event, .i_audio_rx_dma_event, .i_gpio_bank_irq, .i_phy_clk_present,
		.i_phy_power_good, .i_phy_pll_locked, .i_phy_vbus_sense, .i_phy_vbus_valid,
		.i_phy_id_dig, .o_pll_ctrl_write_lock, .o_dma0_tc0_burst_bytes, .o_dma0_tc1_burst_bytes,
		.o_dma1_tc0_burst_bytes, .o_capture_event, .o_host_port_byte_addr_mode,
		.o_host_port_enable, .o_pwm_timebase_clk_run, .o_audio_mute_input, .o_phy_reset,
		.o_ctrl_vbus_valid, .o_ctrl_id_dig, .o_phy_refclk_select, .o_phy_power_down,
		.o_otg_subsystem_power_down, .o_data_line_polarity, .o_phy_pll_keep_on);
	chip_periph_model i_model (.i_mclk, .i_arst_n, .i_vbus_on(vbus_on), .i_phy_reset(o_phy_reset),
		.i_phy_power_down(o_phy_power_down), .o_phy_clk_present(i_phy_clk_present),
		.o_phy_power_good(i_phy_power_good), .o_phy_pll_locked(i_phy_pll_locked),
		.o_phy_vbus_sense(i_phy_vbus_sense));
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", nm, exp, got);
			miscompares++;
		end
	endtask
	task automatic close_out;
		if (miscompares == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic timed_out;
		$display("unexpected handshake expected %h seen %h", 1'b1, 1'b0);
		miscompares++;
		close_out;
	endtask
	// Write address and data are offered together and each is released once taken.
	task automatic wr(input logic [11:0] a, input logic [31:0] dv, output logic [1:0] r);
		@(posedge i_mclk);
		i_awaddr <= a;
		i_wdata <= dv;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		for (int n = 0; n <= 40; n++) begin
			if (n == 40) timed_out;
			@(posedge i_mclk);
			if (i_awvalid && o_awready) i_awvalid <= 1'b0;
			if (i_wvalid && o_wready) i_wvalid <= 1'b0;
			if (o_bvalid) begin
				r = o_bresp;
				i_bready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] dv, output logic [1:0] r);
		@(posedge i_mclk);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		for (int n = 0; n <= 40; n++) begin
			if (n == 40) timed_out;
			@(posedge i_mclk);
			if (i_arvalid && o_arready) i_arvalid <= 1'b0;
			if (o_rvalid) begin
				dv = o_rdata;
				r = o_rresp;
				i_rready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic wr_settle(input logic [11:0] a, input logic [31:0] dv);
		wr(a, dv, rsp);
		repeat (2) @(posedge i_mclk);
	endtask
	initial begin
		{i_arst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, vbus_on} = '0;
		{i_awaddr, i_araddr, i_wdata, i_audio_tx_dma_event, i_audio_rx_dma_event} = '0;
		{i_gpio_bank_irq, i_phy_vbus_valid} = '0;
		i_wstrb = 4'hF;
		i_capture_pin = 3'h5;
		i_phy_id_dig = 1'b1;
		repeat (5) @(posedge i_mclk);
		i_arst_n <= 1'b1;
		rd(12'h000, rdat, rsp);
		chk("cfg0 reset", 32'h00000000, rdat);
		rd(12'h008, rdat, rsp);
		chk("cfg2 reset", 32'h0000EF00, rdat);
		chk("burst reset", {3{7'h10}}, {o_dma0_tc0_burst_bytes, o_dma0_tc1_burst_bytes,
			o_dma1_tc0_burst_bytes});
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d, rsp);
			chk("bresp", rows[i].r, rsp);
			rd(rows[i].a, rdat, rsp);
			chk("rdata", rows[i].e, rdat);
			chk("rresp", rows[i].r, rsp);
		end
		for (v = 0; v < 4; v++) begin
			wr(12'h004, 32'(v << 13), rsp);
			wr_settle(12'h000, 32'(v * 5 + v[0] * 16));
			bx = (v == 1) ? 7'h20 : (v == 2) ? 7'h40 : 7'h10;
			chk("burst", {3{bx}}, {o_dma0_tc0_burst_bytes, o_dma0_tc1_burst_bytes,
				o_dma1_tc0_burst_bytes});
			chk("pll lock", v[0], o_pll_ctrl_write_lock);
		end
		for (p = 0; p < 2; p++) begin
			i_audio_tx_dma_event <= !p[0];
			i_audio_rx_dma_event <= p[0];
			for (v = 0; v < 4; v++) begin
				wr_settle(12'h004, 32'(v * 32'h08420000));
				chk("capture", v == 0 ? 3'h5 : v == 1 + p ? 3'h7 : 3'h0, o_capture_event);
			end
		end
		for (p = 0; p < 2; p++) begin
			i_gpio_bank_irq <= p ? 8'h5A : 8'hA5;
			for (k = 0; k < 16; k++) begin
				wr_settle(12'h004, 32'(k | (k[0] << 16) | (k[1] << 15) | (k[2] << 12)));
				chk("mute", k >= 1 && k <= 8 ? i_gpio_bank_irq[k - 1] : 1'b0, o_audio_mute_input);
				chk("host pwm", {k[0], k[1], k[2]}, {o_host_port_byte_addr_mode, o_host_port_enable,
					o_pwm_timebase_clk_run});
			end
		end
		for (v = 0; v < 4; v++) begin
			d = 32'(v << 13) | (v[0] ? 32'h00008540 : 32'h00000A00);
			wr_settle(12'h008, d);
			chk("otg", v == 0 ? 2'h1 : v == 3 ? 2'h0 : {1'b1, v[1]}, {o_ctrl_vbus_valid,
				o_ctrl_id_dig});
			chk("phy ctl", {d[15], d[11:8], d[6]}, {o_phy_reset, o_phy_refclk_select,
				o_phy_power_down, o_otg_subsystem_power_down, o_data_line_polarity,
				o_phy_pll_keep_on});
		end
		vbus_on <= 1'b1;
		wr_settle(12'h008, 32'h00000000);
		rd(12'h008, rdat, rsp);
		chk("phy status", 32'h00030000, rdat);
		vbus_on <= 1'b0;
		rd(12'h008, rdat, rsp);
		chk("phy status", 32'h00020000, rdat);
		i_wstrb <= 4'h4;
		wr(12'h004, 32'h00000000, rsp);
		i_wstrb <= 4'hF;
		rd(12'h004, rdat, rsp);
		chk("strobe merge", 32'h0000900F, rdat);
		@(posedge i_mclk);
		i_arst_n <= 1'b0;
		repeat (2) @(posedge i_mclk);
		chk("second reset", {1'b1, 1'b1, 7'h10}, {o_phy_reset, o_data_line_polarity,
			o_dma0_tc0_burst_bytes});
		i_arst_n <= 1'b1;
		rd(12'h000, rdat, rsp);
		chk("cfg0 after reset", 32'h00000000, rdat);
		close_out;
	end
endmodule // chip_config_regs_tb_top
`default_nettype wire
